// >>> dv/oabag_mem_model.sv
`timescale 1ns/100ps
// Data and program memory answering combinationally, with data derived from the low address byte only.
module oabag_mem_model (
  input  wire logic [8:0]  dm_addr,
  input  wire logic        dm_rd,
  input  wire logic [14:0] pm_addr,
  output logic      [7:0]  dm_rdata,
  output logic      [7:0]  pm_rdata
);
  // An unselected data bus shows the inverse pattern, so a stale read cannot match by luck.
  always_comb begin
    dm_rdata = dm_rd ? (dm_addr[7:0] ^ 8'hA5) : ~(dm_addr[7:0] ^ 8'hA5);
  end

  // Program memory bytes follow the low address byte, so adjacent vector bytes differ.
  assign pm_rdata = pm_addr[7:0] + 8'h5A;
endmodule : oabag_mem_model

// >>> dv/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import oabag_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, op_valid = 1'b0, op_use_sec = 1'b0, op_step_en = 1'b0;
  logic op_step_down = 1'b0, op_is_ldx = 1'b0, op_class_imm = 1'b0, op_reg_mem = 1'b0;
  logic xfer_valid = 1'b0, pc_inc = 1'b0, cpu_wr = 1'b0;
  logic [7:0] op_field = 8'h00, accum = 8'h00, cpu_wdata = 8'h00, pm_rdata, dm_rdata;
  logic [14:0] xfer_field = 15'h0000, vec_addr = 15'h0000, pm_addr, pc_reg;
  logic [8:0] cpu_addr = 9'h000, dm_addr;
  oabag_mode_t op_mode = OA_DIRECT;
  oabag_xfer_t xfer_kind = TC_NONE;
  logic [7:0] operand, primary_pointer, secondary_pointer, stack_pointer, processor_status_word;
  logic operand_valid, op_illegal, global_interrupt_enable, half_carry_flag, carry_flag, vec_busy, dm_rd;
  logic rd_seen, ill_seen, busy_seen;
  logic [8:0] addr_seen;
  logic [14:0] pm_seen;
  int errors = 0;
  int total_checks = 0;

  oabag_core i_oabag_core (.clk(clk), .rstn(rstn), .op_valid(op_valid), .op_mode(op_mode),
    .op_use_sec(op_use_sec), .op_step_en(op_step_en), .op_step_down(op_step_down),
    .op_is_ldx(op_is_ldx), .op_class_imm(op_class_imm), .op_reg_mem(op_reg_mem),
    .op_field(op_field), .accum(accum), .xfer_valid(xfer_valid), .xfer_kind(xfer_kind),
    .xfer_field(xfer_field), .vec_addr(vec_addr), .pc_inc(pc_inc), .cpu_wr(cpu_wr),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .pm_rdata(pm_rdata), .dm_rdata(dm_rdata),
    .dm_addr(dm_addr), .dm_rd(dm_rd), .operand(operand), .operand_valid(operand_valid),
    .op_illegal(op_illegal), .pm_addr(pm_addr), .pc_reg(pc_reg),
    .primary_pointer(primary_pointer), .secondary_pointer(secondary_pointer),
    .stack_pointer(stack_pointer), .processor_status_word(processor_status_word),
    .global_interrupt_enable(global_interrupt_enable), .half_carry_flag(half_carry_flag),
    .carry_flag(carry_flag), .vec_busy(vec_busy));
  oabag_mem_model i_oabag_mem_model (.dm_addr(dm_addr), .dm_rd(dm_rd), .pm_addr(pm_addr),
    .dm_rdata(dm_rdata), .pm_rdata(pm_rdata));

  // Free-running 50 MHz clock.
  always #10 clk = ~clk;

  // Mismatches are counted here so every comparison reports the same way.
  task automatic chk(input logic [14:0] got, input logic [14:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    if (errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop

  // One core write into the data map, taken at the next rising edge.
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(negedge clk);
    cpu_wr = 1'b1;
    cpu_addr = a;
    cpu_wdata = d;
    @(negedge clk);
    cpu_wr = 1'b0;
  endtask : wr

  // Flags are sec, step_en, step_down, ldx, class_imm, reg_mem; the answer is settled on return.
  task automatic op(input oabag_mode_t m, input logic [7:0] f, input logic [5:0] fl);
    @(negedge clk);
    op_valid = 1'b1;
    op_mode = m;
    op_field = f;
    {op_use_sec, op_step_en, op_step_down, op_is_ldx, op_class_imm, op_reg_mem} = fl;
    #1;
    rd_seen = dm_rd;
    ill_seen = op_illegal;
    addr_seen = dm_addr;
    pm_seen = pm_addr;
    @(negedge clk);
    op_valid = 1'b0;
  endtask : op

  // One transfer of control; vectoring needs two more edges than the others.
  task automatic xf(input oabag_xfer_t k, input logic [14:0] f);
    @(negedge clk);
    xfer_valid = 1'b1;
    xfer_kind = k;
    xfer_field = f;
    #1;
    pm_seen = pm_addr;
    @(negedge clk);
    xfer_valid = 1'b0;
    // The vector's upper byte is addressed in the cycle after the request.
    if (k == TC_VEC) begin
      pm_seen = pm_addr;
      busy_seen = vec_busy;
      repeat (2) @(negedge clk);
    end
  endtask : xf

  // A hang ends the run well after the whole sequence should have finished.
  initial begin
    #200000;
    errors++;
    report_and_stop();
  end

  initial begin
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    chk(pc_reg, PC_RST);
    chk(operand_valid, 1'b0);
    // Pointer indirect through the primary pointer with a downward post-step wrapping past zero.
    op(OA_PTR_POST, 8'h00, 6'b011100);
    chk(addr_seen, 9'h000);
    chk(operand, 8'hA5);
    chk(primary_pointer, 8'h00);
    @(negedge clk);
    chk(primary_pointer, 8'hFF);
    chk(stack_pointer, 8'h00);
    chk(processor_status_word, 8'h00);
    // Secondary pointer into the all-ones range, stepping upward.
    wr(SECPTR_ADDR, 8'h7E);
    op(OA_PTR_POST, 8'h00, 6'b110100);
    chk(operand, ONES);
    @(negedge clk);
    chk(secondary_pointer, 8'h7F);
    op(OA_PTR_POST, 8'h00, 6'b010000);
    chk(ill_seen, 1'b1);
    chk(operand_valid, 1'b0);
    // Direct mode, both ends of the all-ones range and a plain memory byte.
    op(OA_DIRECT, 8'h70, 6'b000000);
    chk(operand, ONES);
    op(OA_DIRECT, 8'h7F, 6'b000000);
    chk(operand, ONES);
    op(OA_DIRECT, 8'h20, 6'b000000);
    chk(addr_seen, 9'h020);
    chk(operand, 8'h85);
    // Immediate data only where the operand class allows it.
    op(OA_IMM, 8'h3C, 6'b000010);
    chk(rd_seen, 1'b0);
    chk(operand, 8'h3C);
    op(OA_IMM, 8'h3C, 6'b000000);
    chk(ill_seen, 1'b1);
    chk(operand_valid, 1'b0);
    op(OA_SHORT, 8'h0B, 6'b000000);
    chk(primary_pointer, 8'h0B);
    // Plain pointer indirect with no step reads through the primary pointer.
    op(OA_PTR_IND, 8'h00, 6'b000000);
    chk(addr_seen, 9'h00B);
    chk(operand, 8'hAE);
    // Register memory must stay inside F0 to FF.
    op(OA_DIRECT, 8'h20, 6'b000001);
    chk(ill_seen, 1'b1);
    wr(9'h0F5, 8'h99);
    op(OA_DIRECT, 8'hF5, 6'b000001);
    chk(operand, 8'h99);
    wr(STKPTR_ADDR, 8'h55);
    op(OA_DIRECT, 8'hFD, 6'b000001);
    chk(operand, 8'h55);
    wr(PSW_ADDR, 8'h41);
    chk({half_carry_flag, carry_flag, global_interrupt_enable}, 3'b011);
    // Program memory data load with the accumulator as the low address byte.
    accum = 8'h12;
    op(OA_PROG_IND, 8'h00, 6'b000000);
    chk(pm_seen, 15'h0012);
    chk(operand, 8'h6C);
    // Transfers of control; the absolute, relative and indirect ones build on the counter left by the last.
    xf(TC_LONG, 15'h4321);
    chk(pc_reg, 15'h4321);
    xf(TC_ABS, 15'h0ABC);
    chk(pc_reg, 15'h4ABC);
    xf(TC_REL, 15'h0020);
    chk(pc_reg, 15'h4ADC);
    xf(TC_REL, 15'h0061);
    chk(pc_reg, 15'h4ABD);
    xf(TC_REL, 15'h0001);
    chk(pc_reg, 15'h4ABE);
    accum = 8'h33;
    xf(TC_IND, 15'h0000);
    chk(pm_seen, 15'h4A33);
    chk(pc_reg, 15'h4A8D);
    vec_addr = 15'h0100;
    xf(TC_VEC, 15'h0000);
    chk(pm_seen, 15'h0100);
    chk(busy_seen, 1'b1);
    chk(vec_busy, 1'b0);
    chk(pc_reg, 15'h5A5B);
    @(negedge clk);
    pc_inc = 1'b1;
    @(negedge clk);
    pc_inc = 1'b0;
    chk(pc_reg, 15'h5A5C);
    // A reset in mid-run returns the counter and the pointers to zero.
    @(negedge clk);
    rstn = 1'b0;
    @(negedge clk);
    rstn = 1'b1;
    chk(pc_reg, PC_RST);
    chk(primary_pointer, REG_RST);
    chk(secondary_pointer, REG_RST);
    report_and_stop();
  end
endmodule : tb_top

// >>> src/oabag_core.sv
`timescale 1ns/100ps
// Functional notes
// - Data reads from 0070H to 007FH return FFH.
// - Unused data addresses may read undefined; here data memory passes through.
// - Pointer-indirect operand address comes from primary or secondary pointer.
// - Load and exchange may post-step the pointer after the access.
// - Direct mode uses the 8-bit address field unchanged.
// - Immediate mode delivers the 8-bit field, no memory access.
// - Short immediate carries a 4-bit field for the primary pointer load.
// - Program-memory data load uses accumulator as low address byte.
// - Relative jump adds -31..+32 to full 15-bit counter; +1 is no-op.
// - Absolute jump and call replace only the low 12 counter bits.
// - Long jump and call replace all 15 counter bits.
// - Indirect jump loads fetched byte into counter low byte.
// - Vectoring fetches two adjacent vector bytes into the counter.
// - Counter is 15 bits: 7-bit upper part and 8-bit lower part.
// - Status word holds carry, half-carry and global interrupt enable.
// - Register-memory operands are limited to F0..FF.
// - F0..FB decode to register RAM.
// - 0100..013F decode to a 64-byte RAM block.
// - Stack pointer and both memory pointers are 8 bits.
// - Operand classes: direct or primary target; second class adds immediate.
module oabag_core (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic                  op_valid,
  input  wire oabag_pkg::oabag_mode_t op_mode,
  input  wire logic                  op_use_sec,
  input  wire logic                  op_step_en,
  input  wire logic                  op_step_down,
  input  wire logic                  op_is_ldx,
  input  wire logic                  op_class_imm,
  input  wire logic                  op_reg_mem,
  input  wire logic [7:0]            op_field,
  input  wire logic [7:0]            accum,
  input  wire logic                  xfer_valid,
  input  wire oabag_pkg::oabag_xfer_t xfer_kind,
  input  wire logic [14:0]           xfer_field,
  input  wire logic [14:0]           vec_addr,
  input  wire logic                  pc_inc,
  input  wire logic                  cpu_wr,
  input  wire logic [8:0]            cpu_addr,
  input  wire logic [7:0]            cpu_wdata,
  input  wire logic [7:0]            pm_rdata,
  input  wire logic [7:0]            dm_rdata,
  output logic [8:0]                 dm_addr,
  output logic                       dm_rd,
  output logic [7:0]                 operand,
  output logic                       operand_valid,
  output logic                       op_illegal,
  output logic [14:0]                pm_addr,
  output logic [14:0]                pc_reg,
  output logic [7:0]                 primary_pointer,
  output logic [7:0]                 secondary_pointer,
  output logic [7:0]                 stack_pointer,
  output logic [7:0]                 processor_status_word,
  output logic                       global_interrupt_enable,
  output logic                       half_carry_flag,
  output logic                       carry_flag,
  output logic                       vec_busy
);
  import oabag_pkg::*;

  logic [7:0]  pri_reg, sec_reg, stk_reg, psw_reg, top_reg;
  logic [7:0]  regram [0:11];
  logic [7:0]  hiram [0:63];
  logic [8:0]  acc_addr;
  logic        acc_read;
  logic        step_pend_reg;
  logic        step_sec_reg;
  logic        step_down_reg;
  oabag_vst_t  vst_reg;
  logic [14:0] pc_next;
  logic [6:0]  pc_upper_part;
  logic [7:0]  pc_lower_part;
  logic [7:0]  vector_upper_byte;
  logic [7:0]  mapped_rd;
  logic        mapped_hit;
  logic signed [6:0] rel_disp;

  // True when an address lies between two bounds, both bounds included.
  function automatic logic in_range(input logic [8:0] a, input logic [8:0] lo, input logic [8:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  // Read decode of the core-owned part of the data map.
  function automatic logic [8:0] rd_sel(input logic [8:0] a);
    rd_sel = 9'h000;
    if (in_range(a, ONES_LO, ONES_HI)) rd_sel[0] = 1'b1;
    else if (a == PSW_ADDR) rd_sel[1] = 1'b1;
    else if (in_range(a, REGRAM_LO, REGRAM_HI)) rd_sel[2] = 1'b1;
    else if (a == SECPTR_ADDR) rd_sel[3] = 1'b1;
    else if (a == STKPTR_ADDR) rd_sel[4] = 1'b1;
    else if (a == PRIPTR_ADDR) rd_sel[5] = 1'b1;
    else if (a == TOPREG_ADDR) rd_sel[6] = 1'b1;
    else if (in_range(a, HIRAM_LO, HIRAM_HI)) rd_sel[7] = 1'b1;
    else rd_sel[8] = 1'b1;
  endfunction : rd_sel

  assign pc_upper_part = pc_reg[14:8];
  assign pc_lower_part = pc_reg[7:0];
  assign rel_disp      = 7'(signed'(xfer_field[6:0]));

  // Operand address formation; immediates never touch data memory.
  always_comb begin
    acc_addr   = 9'h000;
    acc_read   = 1'b0;
    op_illegal = 1'b0;
    if (op_valid) begin
      case (op_mode)
        OA_PTR_IND, OA_PTR_POST: begin
          acc_addr = {1'b0, (op_use_sec ? sec_reg : pri_reg)};
          acc_read = 1'b1;
          // Only load and exchange may post-step the pointer.
          if (op_mode == OA_PTR_POST && !op_is_ldx) op_illegal = 1'b1;
        end
        OA_DIRECT: begin
          acc_addr = {1'b0, op_field};
          acc_read = 1'b1;
          if (op_reg_mem && op_field[7:4] != REG_PAGE[3:0]) op_illegal = 1'b1;
        end
        OA_IMM: begin
          if (!op_class_imm) op_illegal = 1'b1;
        end
        OA_SHORT: acc_read = 1'b0;
        OA_PROG_IND: acc_read = 1'b0;
        default: op_illegal = 1'b1;
      endcase
    end
  end

  assign dm_addr = acc_addr;
  assign dm_rd   = acc_read && !op_illegal;

  // Read mux for the core-owned bytes; other addresses come from outside.
  // The operand's own address picks the byte, so pointer and direct reads see the same map.
  always_comb begin
    logic [8:0] s;
    s          = rd_sel(acc_addr);
    mapped_hit = ~s[8];
    mapped_rd  = 8'h00;
    case (1'b1)
      s[0]: mapped_rd = ONES;
      s[1]: mapped_rd = psw_reg;
      s[2]: mapped_rd = regram[4'(acc_addr - REGRAM_LO)];
      s[3]: mapped_rd = sec_reg;
      s[4]: mapped_rd = stk_reg;
      s[5]: mapped_rd = pri_reg;
      s[6]: mapped_rd = top_reg;
      s[7]: mapped_rd = hiram[6'(acc_addr - HIRAM_LO)];
      default: mapped_rd = 8'h00;
    endcase
  end

  // Operand register: immediate fields, program bytes or memory data.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      operand       <= REG_RST;
      operand_valid <= 1'b0;
    end else begin
      operand_valid <= op_valid && !op_illegal;
      // The operand holds between requests, so a consumer may read it late.
      if (op_valid && !op_illegal) begin
        case (op_mode)
          OA_IMM:      operand <= op_field;
          OA_SHORT:    operand <= {4'h0, op_field[3:0]};
          OA_PROG_IND: operand <= pm_rdata;
          default:     operand <= mapped_hit ? mapped_rd : dm_rdata;
        endcase
      end
    end
  end

  // Mapped registers; a post-step is applied the cycle after the access.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pri_reg       <= REG_RST;
      sec_reg       <= REG_RST;
      stk_reg       <= REG_RST;
      psw_reg       <= REG_RST;
      top_reg       <= REG_RST;
      step_pend_reg <= 1'b0;
      step_sec_reg  <= 1'b0;
      step_down_reg <= 1'b0;
    end else begin
      step_pend_reg <= op_valid && op_mode == OA_PTR_POST && op_is_ldx && op_step_en;
      step_sec_reg  <= op_use_sec;
      step_down_reg <= op_step_down;
      if (cpu_wr) begin
        case (cpu_addr)
          PSW_ADDR:    psw_reg <= cpu_wdata;
          SECPTR_ADDR: sec_reg <= cpu_wdata;
          STKPTR_ADDR: stk_reg <= cpu_wdata;
          PRIPTR_ADDR: pri_reg <= cpu_wdata;
          TOPREG_ADDR: top_reg <= cpu_wdata;
          default: ;
        endcase
      end
      if (op_valid && op_mode == OA_SHORT) pri_reg <= {4'h0, op_field[3:0]};
      // The step wins over a write in the same cycle to keep the access order.
      if (step_pend_reg) begin
        if (step_sec_reg) sec_reg <= step_down_reg ? sec_reg - 8'h01 : sec_reg + 8'h01;
        else pri_reg <= step_down_reg ? pri_reg - 8'h01 : pri_reg + 8'h01;
      end
    end
  end

  // RAM arrays have no reset; their contents are undefined at power-up.
  always_ff @(posedge clk) begin
    if (cpu_wr && in_range(cpu_addr, REGRAM_LO, REGRAM_HI)) regram[4'(cpu_addr - REGRAM_LO)] <= cpu_wdata;
    if (cpu_wr && in_range(cpu_addr, HIRAM_LO, HIRAM_HI)) hiram[6'(cpu_addr - HIRAM_LO)] <= cpu_wdata;
  end

  assign primary_pointer         = pri_reg;
  assign secondary_pointer       = sec_reg;
  assign stack_pointer           = stk_reg;
  assign processor_status_word   = psw_reg;
  assign global_interrupt_enable = psw_reg[PSW_GIE_BIT];
  assign carry_flag              = psw_reg[PSW_CRY_BIT];
  assign half_carry_flag         = psw_reg[PSW_HC_BIT];
  assign vec_busy                = (vst_reg != VS_IDLE);

  // Program-memory address: table lookups use the accumulator as low byte.
  always_comb begin
    pm_addr = pc_reg;
    if (vst_reg == VS_UPR) pm_addr = vec_addr;
    else if (vst_reg == VS_LWR) pm_addr = vec_addr + 15'h0001;
    else if ((op_valid && op_mode == OA_PROG_IND) || (xfer_valid && xfer_kind == TC_IND))
      pm_addr = {pc_upper_part, accum};
  end

  // Next program counter value for each kind of transfer.
  always_comb begin
    pc_next = pc_inc ? pc_reg + 15'h0001 : pc_reg;
    if (vst_reg == VS_LWR) pc_next = {vector_upper_byte[6:0], pm_rdata};
    else if (xfer_valid && vst_reg == VS_IDLE) begin
      case (xfer_kind)
        TC_REL:
          if (rel_disp >= REL_MIN && rel_disp <= REL_MAX && rel_disp != 7'sd1)
            pc_next = pc_reg + 15'(signed'(rel_disp));
          else pc_next = pc_reg + 15'h0001;
        TC_ABS:  pc_next = {pc_reg[14:12], xfer_field[11:0]};
        TC_LONG: pc_next = xfer_field;
        TC_IND:  pc_next = {pc_upper_part, pm_rdata};
        default: ;
      endcase
    end
  end

  // Vectoring sequence: upper byte then lower byte, then the counter loads.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vst_reg           <= VS_IDLE;
      vector_upper_byte <= REG_RST;
      pc_reg            <= PC_RST;
    end else begin
      pc_reg <= pc_next;
      case (vst_reg)
        VS_IDLE: if (xfer_valid && xfer_kind == TC_VEC) vst_reg <= VS_UPR;
        VS_UPR: begin
          vector_upper_byte <= pm_rdata;
          vst_reg           <= VS_LWR;
        end
        VS_LWR:  vst_reg <= VS_IDLE;
        default: vst_reg <= VS_IDLE;
      endcase
    end
  end

  // Transfer and operand checks; each one watches only what this block drives.
  rel_range_a: assert property (@(posedge clk) disable iff (!rstn)
    (xfer_valid && vst_reg == VS_IDLE && xfer_kind == TC_REL && rel_disp == 7'sd1) |=>
    pc_reg == $past(pc_reg) + 15'h0001) else $error("Relative +1 did not act as no-op.");
  abs_keep_a: assert property (@(posedge clk) disable iff (!rstn)
    (xfer_valid && vst_reg == VS_IDLE && xfer_kind == TC_ABS) |=>
    pc_reg[14:12] == $past(pc_reg[14:12]) && pc_reg[11:0] == $past(xfer_field[11:0]))
    else $error("Absolute jump changed segment.");
  long_load_a: assert property (@(posedge clk) disable iff (!rstn)
    (xfer_valid && vst_reg == VS_IDLE && xfer_kind == TC_LONG) |=> pc_reg == $past(xfer_field))
    else $error("Long jump target wrong.");
  vec_seq_a: assert property (@(posedge clk) disable iff (!rstn)
    (vst_reg == VS_IDLE && xfer_valid && xfer_kind == TC_VEC) |=> vst_reg == VS_UPR ##1 vst_reg == VS_LWR
    ##1 pc_reg[7:0] == $past(pm_rdata)) else $error("Vector sequence broken.");
  ones_read_a: assert property (@(posedge clk) disable iff (!rstn)
    (!op_illegal && op_valid && op_mode == OA_DIRECT && op_field[7:4] == 4'h7) |=> operand == ONES)
    else $error("Reserved range did not read ones.");
  imm_noread_a: assert property (@(posedge clk) disable iff (!rstn)
    (op_valid && op_mode == OA_IMM) |-> !dm_rd ##1 (operand == $past(op_field) || !operand_valid))
    else $error("Immediate accessed memory.");
  ptr_addr_a: assert property (@(posedge clk) disable iff (!rstn)
    (op_valid && op_mode == OA_PTR_IND) |-> dm_addr[7:0] == (op_use_sec ? sec_reg : pri_reg))
    else $error("Pointer address wrong.");
  // A post-step lands two edges after the request and moves the pointer by one, modulo 256.
  post_step_a: assert property (@(posedge clk) disable iff (!rstn)
    (op_valid && op_mode == OA_PTR_POST && op_is_ldx && op_step_en && !op_use_sec) |=>
    ##1 (pri_reg == $past(pri_reg) + ($past(op_step_down, 2) ? 8'hFF : 8'h01)))
    else $error("Post-step wrong.");
  sec_step_a: assert property (@(posedge clk) disable iff (!rstn)
    (op_valid && op_mode == OA_PTR_POST && op_is_ldx && op_step_en && op_use_sec) |=>
    ##1 (sec_reg == $past(sec_reg) + ($past(op_step_down, 2) ? 8'hFF : 8'h01)))
    else $error("Secondary post-step wrong.");
  // Table lookups keep the counter's upper part; only the low byte comes from the accumulator.
  prog_ind_a: assert property (@(posedge clk) disable iff (!rstn)
    (op_valid && op_mode == OA_PROG_IND && vst_reg == VS_IDLE) |-> pm_addr == {pc_reg[14:8], accum})
    else $error("Table lookup address wrong.");

endmodule : oabag_core

// >>> src/oabag_pkg.sv
package oabag_pkg;

  // Data-memory map (9-bit data address space).
  localparam logic [8:0] ONES_LO      = 9'h070;
  localparam logic [8:0] ONES_HI      = 9'h07F;
  localparam logic [8:0] PSW_ADDR     = 9'h0EF;
  localparam logic [8:0] REGRAM_LO    = 9'h0F0;
  localparam logic [8:0] REGRAM_HI    = 9'h0FB;
  localparam logic [8:0] SECPTR_ADDR  = 9'h0FC;
  localparam logic [8:0] STKPTR_ADDR  = 9'h0FD;
  localparam logic [8:0] PRIPTR_ADDR  = 9'h0FE;
  localparam logic [8:0] TOPREG_ADDR  = 9'h0FF;
  localparam logic [8:0] HIRAM_LO     = 9'h100;
  localparam logic [8:0] HIRAM_HI     = 9'h13F;
  localparam logic [7:0] REG_PAGE     = 8'h0F;

  // Status word field positions.
  localparam int PSW_GIE_BIT = 0;
  localparam int PSW_CRY_BIT = 6;
  localparam int PSW_HC_BIT  = 7;

  // Reset values and the reserved-range read value.
  localparam logic [7:0]  REG_RST = 8'h00;
  localparam logic [14:0] PC_RST  = 15'h0000;
  localparam logic [7:0]  ONES    = 8'hFF;

  // Relative jump range.
  localparam logic signed [6:0] REL_MIN = -7'sd31;
  localparam logic signed [6:0] REL_MAX = 7'sd32;

  // Operand addressing modes.
  typedef enum logic [5:0] {
    OA_PTR_IND  = 6'h01,
    OA_PTR_POST = 6'h02,
    OA_DIRECT   = 6'h04,
    OA_IMM      = 6'h08,
    OA_SHORT    = 6'h10,
    OA_PROG_IND = 6'h20
  } oabag_mode_t;

  // Transfer-of-control kinds.
  typedef enum logic [5:0] {
    TC_NONE = 6'h01,
    TC_REL  = 6'h02,
    TC_ABS  = 6'h04,
    TC_LONG = 6'h08,
    TC_IND  = 6'h10,
    TC_VEC  = 6'h20
  } oabag_xfer_t;

  // Vectoring sequence states.
  typedef enum logic [2:0] {
    VS_IDLE = 3'h1,
    VS_UPR  = 3'h2,
    VS_LWR  = 3'h4
  } oabag_vst_t;

endpackage : oabag_pkg
